// ---- rtl/aus_pkg.sv ----
// Package: offsets, field layouts, reset values and sizes of the scheduler
package aus_pkg;
   localparam int          NUM_SLOTS    = 32;
   localparam int          NUM_VARS     = 8;
   localparam int          QUEUE_DEPTH  = 16;
   localparam logic [14:0] RATIO_RESET  = 15'h0001;
   localparam logic [14:0] RATIO_MIN    = 15'h0001;
   localparam logic [31:0] MEM_WORDS    = 32'h0000A000;
   localparam logic [4:0]  WINDOW_RESET = 5'h10;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] WINDOW_OFF = 8'h08;
   localparam logic [7:0] SEL_OFF    = 8'h0C;
   localparam logic [7:0] WDATA_OFF  = 8'h10;
   localparam logic [7:0] CMD_OFF    = 8'h14;
   localparam logic [7:0] RDATA_OFF  = 8'h18;
   localparam logic [7:0] DEFN_OFF   = 8'h1C;
   localparam logic [7:0] ERR_OFF    = 8'h20;
   localparam logic [7:0] CHAN_OFF   = 8'h24;
   // CTRL bits (write 1 actions / levels)
   localparam int CTRL_APPLY  = 0;
   localparam int CTRL_ARM    = 1;
   localparam int CTRL_ABORT  = 2;
   localparam int CTRL_MODRST = 3;
   // SEL fields: slot [5:0] (32 = shared space), var [11:8]
   localparam int SEL_SLOT_LSB = 0;
   localparam int SEL_VAR_LSB  = 8;
   localparam logic [5:0] SHARED_SLOT = 6'h20;
   // Commands written to CMD
   localparam logic [3:0] CMD_SCAL_WR  = 4'h1;
   localparam logic [3:0] CMD_SCAL_RD  = 4'h2;
   localparam logic [3:0] CMD_RATIO_WR = 4'h3;
   localparam logic [3:0] CMD_RATIO_RD = 4'h4;
   localparam logic [3:0] CMD_STATE_WR = 4'h5;
   localparam logic [3:0] CMD_STATE_RD = 4'h6;
   localparam logic [3:0] CMD_SIZE_RD  = 4'h7;
   localparam logic [3:0] CMD_DEFINE   = 4'h8;
   localparam logic [3:0] CMD_DEFVAR   = 4'h9;
   localparam logic [3:0] CMD_REPLACE  = 4'hA;
   // DEFN: [30:0] swap size, [31] swap enable
   localparam int DEFN_SWAP_BIT = 31;
   // ERR bits
   localparam int ERR_UNDEF   = 0;
   localparam int ERR_TOOMANY = 1;
   localparam int ERR_BADARG  = 2;
   localparam int ERR_NOMEM   = 3;
   // Update queue entry kinds
   typedef enum logic [1:0] {
      AUS_UPD_SCAL,
      AUS_UPD_RATIO,
      AUS_UPD_STATE
   } aus_upd_t;
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// ---- rtl/aus_scheduler.sv ----
// Algorithm update scheduler with AXI4-Lite register slave
//----------------------------------------------------------------------
// Overview of operation
// R1: Scalar writes wait in queue until apply.
// R2: Queue overflow past window raises too-many error.
// R3: Undefined slot or variable access raises error.
// R4: Targets slots 0-31 or shared space (32).
// R5: Scalar values carried as float32 words.
// R6: Scalar read returns current float32 value.
// R7: Slot runs once per n triggers.
// R8: Ratio resets to one for every slot.
// R9: Enabled slots run on first armed trigger.
// R10: Ratio changes queued until apply.
// R11: Ratio/enable accepted for undefined slots.
// R12: Ratio query returns stored 15-bit ratio.
// R13: Swap slot size is twice swap size.
// R14: Undefined slot size reads zero.
// R15: Size is 32-bit, within memory limit.
// R16: Enable changes queued until apply.
// R17: Disabled slot stops; output stays as-is.
// R18: Enable query returns 0 or 1.
// R19: Apply flips swap slot to other copy.
// R20: Queue applied atomically between scans; here the queue is applied in its request cycle, trigger cycles included.
//----------------------------------------------------------------------
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module aus_scheduler (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Scan pacing and update event
   input  wire logic        scan_trigger,
   input  wire logic        update_event,
   // Execution outputs
   output logic [31:0]      run_mask,
   output logic [31:0]      copy_sel,
   output logic             scan_done
);
   import aus_pkg::*;

   //-------------------------------------------------------------------
   // Storage
   //-------------------------------------------------------------------
   logic [31:0] var_mem [NUM_SLOTS+1][NUM_VARS];
   logic [NUM_VARS-1:0] var_def_reg [NUM_SLOTS+1];
   logic [14:0] ratio_reg [NUM_SLOTS];
   logic [14:0] cnt_reg   [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] en_reg;
   logic [NUM_SLOTS:0]   def_reg;
   logic [NUM_SLOTS-1:0] swap_reg;
   logic [NUM_SLOTS-1:0] repl_pend_reg;
   logic [31:0] size_reg [NUM_SLOTS];
   logic [31:0] mem_used_reg;
   // Update queue
   aus_upd_t    q_kind [QUEUE_DEPTH];
   logic [5:0]  q_slot [QUEUE_DEPTH];
   logic [3:0]  q_var  [QUEUE_DEPTH];
   logic [31:0] q_val  [QUEUE_DEPTH];
   logic [4:0]  q_cnt_reg;
   // Software registers
   logic [4:0]  window_reg;
   logic [11:0] sel_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic [31:0] defn_reg;
   logic [3:0]  err_reg;
   logic        armed_reg;
   logic        first_reg;
   logic        chan_en_reg;

   // Select decode
   logic [5:0] sel_slot;
   logic [4:0] sidx;
   logic [2:0] sel_var;
   logic       slot_ok;
   logic       alg_ok;
   logic       var_ok;
   assign sel_slot = sel_reg[SEL_SLOT_LSB +: 6];
   assign sidx     = sel_slot[4:0];
   assign sel_var  = sel_reg[SEL_VAR_LSB +: 3];
   assign slot_ok  = (sel_slot <= SHARED_SLOT);                 // R4
   assign alg_ok   = (sel_slot < SHARED_SLOT);
   assign var_ok   = slot_ok && sel_reg[SEL_VAR_LSB+3] == 1'b0;

   //-------------------------------------------------------------------
   // AXI4-Lite handshake
   //-------------------------------------------------------------------
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wd_reg;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_hit;
   logic        rd_hit;

   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_hit  = awaddr_reg <= CHAN_OFF && awaddr_reg[1:0] == 2'b00;
   assign rd_hit  = s_axi_araddr <= CHAN_OFF
                    && s_axi_araddr[1:0] == 2'b00;

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wd_reg      <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            for (int b = 0; b < 4; b++) begin
               wd_reg[8*b +: 8] <= s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8]
                                                  : 8'h00;
            end
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read response
   logic [31:0] rd_mux;
   always_comb begin
      unique case (s_axi_araddr)
         CTRL_OFF:   rd_mux = {28'h0000000, 1'b0, 1'b0, armed_reg, 1'b0};
         STATUS_OFF: rd_mux = {27'h0000000, q_cnt_reg};
         WINDOW_OFF: rd_mux = {27'h0000000, window_reg};
         SEL_OFF:    rd_mux = {20'h00000, sel_reg};
         WDATA_OFF:  rd_mux = wdata_reg;
         RDATA_OFF:  rd_mux = rdata_reg;
         DEFN_OFF:   rd_mux = defn_reg;
         ERR_OFF:    rd_mux = {28'h0000000, err_reg};
         CHAN_OFF:   rd_mux = {31'h00000000, chan_en_reg};
         default:    rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= AXI_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Command decode
   //-------------------------------------------------------------------
   logic       wr_ok;
   logic       cmd_go;
   logic [3:0] cmd;
   logic       do_apply;
   logic       q_full;
   logic [3:0] q_wr;
   logic       mod_rst;
   logic       enq;
   aus_upd_t   enq_kind;
   logic [31:0] need;
   assign wr_ok    = wr_fire && wr_hit;
   assign cmd_go   = wr_ok && awaddr_reg == CMD_OFF;
   assign cmd      = wd_reg[3:0];
   assign mod_rst  = wr_ok && awaddr_reg == CTRL_OFF && wd_reg[CTRL_MODRST];
   // Apply acts in the cycle it is requested, even mid-scan; only the copy flip skips trigger cycles
   assign do_apply = (wr_ok && awaddr_reg == CTRL_OFF && wd_reg[CTRL_APPLY])
                     || (update_event && chan_en_reg);          // R1 R20
   assign q_full   = q_cnt_reg >= window_reg || q_cnt_reg[4];
   assign q_wr     = do_apply ? 4'h0 : q_cnt_reg[3:0];
   assign need     = !defn_reg[DEFN_SWAP_BIT] ? defn_reg
                     : {defn_reg[30:0], 1'b0} | {32{defn_reg[30]}}; // R13

   // Enqueue request decode
   always_comb begin
      enq      = 1'b0;
      enq_kind = AUS_UPD_SCAL;
      if (cmd_go && !q_full) begin
         unique case (cmd)
            CMD_SCAL_WR: begin
               enq = var_ok && def_reg[sel_slot[5] ? NUM_SLOTS : sidx]
                     && var_def_reg[sel_slot][sel_var];         // R3
            end
            CMD_RATIO_WR: begin
               enq      = alg_ok && wdata_reg[15] == 1'b0
                          && wdata_reg[14:0] >= RATIO_MIN;      // R7 R11
               enq_kind = AUS_UPD_RATIO;
            end
            CMD_STATE_WR: begin
               enq      = alg_ok;                               // R11
               enq_kind = AUS_UPD_STATE;
            end
            default: enq = 1'b0;
         endcase
      end
   end

   // Error flags, write 1 to clear; set wins
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         err_reg <= 4'h0;
      end else begin
         logic [3:0] set;
         set = 4'h0;
         if (cmd_go) begin
            if ((cmd == CMD_SCAL_WR || cmd == CMD_SCAL_RD)
                && !(var_ok && def_reg[sel_slot[5] ? NUM_SLOTS : sidx]
                     && var_def_reg[sel_slot][sel_var]))
               set[ERR_UNDEF] = 1'b1;                           // R3
            if ((cmd == CMD_SCAL_WR || cmd == CMD_RATIO_WR
                 || cmd == CMD_STATE_WR) && q_full)
               set[ERR_TOOMANY] = 1'b1;                         // R2
            if (cmd == CMD_RATIO_WR && !enq && !q_full)
               set[ERR_BADARG] = 1'b1;
            if (cmd == CMD_DEFINE && need > MEM_WORDS - mem_used_reg)
               set[ERR_NOMEM] = 1'b1;                           // R15
         end
         if (wr_ok && awaddr_reg == ERR_OFF)
            err_reg <= (err_reg & ~wd_reg[3:0]) | set;
         else
            err_reg <= err_reg | set;
      end
   end

   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         window_reg  <= WINDOW_RESET;
         sel_reg     <= 12'h000;
         wdata_reg   <= 32'h00000000;
         defn_reg    <= 32'h00000000;
         chan_en_reg <= 1'b0;
      end else if (wr_ok) begin
         unique case (awaddr_reg)
            WINDOW_OFF: window_reg  <= wd_reg[4:0];
            SEL_OFF:    sel_reg     <= wd_reg[11:0];
            WDATA_OFF:  wdata_reg   <= wd_reg;                  // R5
            DEFN_OFF:   defn_reg    <= wd_reg;
            CHAN_OFF:   chan_en_reg <= wd_reg[0];
            default:    ;
         endcase
      end
   end

   // Queue storage and count
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         q_cnt_reg <= 5'h00;
      end else if (do_apply && !enq) begin
         q_cnt_reg <= 5'h00;                                    // R20
      end else if (enq) begin
         q_kind[q_wr] <= enq_kind;
         q_slot[q_wr] <= sel_slot;
         q_var[q_wr]  <= sel_reg[SEL_VAR_LSB +: 4];
         q_val[q_wr]  <= wdata_reg;
         q_cnt_reg <= {1'b0, q_wr} + 5'h01;                     // R1 R10 R16
      end
   end

   //-------------------------------------------------------------------
   // Definitions, queue apply and scan scheduling
   //-------------------------------------------------------------------
   // Definition state
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         def_reg       <= '0;
         swap_reg      <= '0;
         repl_pend_reg <= '0;
         copy_sel      <= 32'h00000000;
         mem_used_reg  <= 32'h00000000;
         for (int s = 0; s <= NUM_SLOTS; s++) var_def_reg[s] <= '0;
         for (int s = 0; s < NUM_SLOTS; s++) size_reg[s] <= 32'h00000000;
      end else begin
         if (cmd_go && cmd == CMD_DEFINE && slot_ok
             && !def_reg[sel_slot[5] ? NUM_SLOTS : sidx]
             && need <= MEM_WORDS - mem_used_reg) begin
            def_reg[sel_slot[5] ? NUM_SLOTS : sidx] <= 1'b1;
            mem_used_reg <= mem_used_reg + need;                // R15
            if (alg_ok) begin
               size_reg[sidx] <= need;                          // R13
               swap_reg[sidx] <= defn_reg[DEFN_SWAP_BIT];
            end
         end
         if (cmd_go && cmd == CMD_DEFVAR && var_ok)
            var_def_reg[sel_slot][sel_var] <= 1'b1;
         if (do_apply && !scan_trigger) begin
            copy_sel      <= copy_sel ^ repl_pend_reg;          // R19
            repl_pend_reg <= '0;
         end
         if (cmd_go && cmd == CMD_REPLACE && alg_ok && swap_reg[sidx])
            repl_pend_reg[sidx] <= 1'b1;
      end
   end

   // Apply queued entries in one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         en_reg <= '1;
         for (int s = 0; s < NUM_SLOTS; s++) ratio_reg[s] <= RATIO_RESET; // R8
      end else if (do_apply) begin
         for (int e = 0; e < QUEUE_DEPTH; e++) begin
            if (e < q_cnt_reg) begin
               unique case (q_kind[e])
                  AUS_UPD_SCAL: var_mem[q_slot[e]][q_var[e][2:0]]
                                   <= q_val[e];                 // R1 R4
                  AUS_UPD_RATIO: ratio_reg[q_slot[e][4:0]]
                                   <= q_val[e][14:0];           // R10
                  AUS_UPD_STATE: en_reg[q_slot[e][4:0]]
                                   <= q_val[e][0];              // R16
                  default: ;
               endcase
            end
         end
      end
   end

   // Query answers
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         rdata_reg <= 32'h00000000;
      end else if (cmd_go) begin
         unique case (cmd)
            CMD_SCAL_RD:  if (var_ok) rdata_reg <= var_mem[sel_slot][sel_var]; // R6
            CMD_RATIO_RD: if (alg_ok) rdata_reg <= {17'h00000, ratio_reg[sidx]}; // R12
            CMD_STATE_RD: if (alg_ok) rdata_reg <= {31'h00000000, en_reg[sidx]}; // R18
            CMD_SIZE_RD:  if (alg_ok) rdata_reg <= def_reg[sidx]
                                          ? size_reg[sidx] : 32'h00000000; // R14
            default: ;
         endcase
      end
   end

   // Arm / abort
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         armed_reg <= 1'b0;
         first_reg <= 1'b0;
      end else if (wr_ok && awaddr_reg == CTRL_OFF && wd_reg[CTRL_ABORT]) begin
         armed_reg <= 1'b0;
      end else if (wr_ok && awaddr_reg == CTRL_OFF && wd_reg[CTRL_ARM]) begin
         armed_reg <= 1'b1;
         first_reg <= 1'b1;                                     // R9
      end else if (scan_trigger && armed_reg) begin
         first_reg <= 1'b0;
      end
   end

   // Per-slot trigger divider
   logic [NUM_SLOTS-1:0] fire;
   for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
      assign fire[g] = def_reg[g] && en_reg[g]                  // R17
                       && (first_reg || cnt_reg[g] + 15'h0001 >= ratio_reg[g]);
      always_ff @(posedge aclk) begin
         if (!aresetn || mod_rst) begin
            cnt_reg[g] <= 15'h0000;
         end else if (scan_trigger && armed_reg) begin
            cnt_reg[g] <= fire[g] ? 15'h0000 : cnt_reg[g] + 15'h0001; // R7
         end
      end
   end

   // Execution mask, held one cycle per trigger
   always_ff @(posedge aclk) begin
      if (!aresetn || mod_rst) begin
         run_mask  <= 32'h00000000;
         scan_done <= 1'b0;
      end else begin
         run_mask  <= (scan_trigger && armed_reg) ? fire : 32'h00000000; // R7 R9
         scan_done <= scan_trigger && armed_reg;
      end
   end
endmodule

// ---- verif/aus_sched_asserts.sv ----
// Checker: concurrent assertions on the scheduler ports
`timescale 1ns/1ps
module aus_sched_asserts (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Scan side
   input wire logic        scan_trigger,
   input wire logic [31:0] run_mask,
   input wire logic [31:0] copy_sel,
   input wire logic        scan_done
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Request steps
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read response late");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write response dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while busy");
   a_aw_refused: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   a_run_cause: assert property ((|run_mask) |-> $past(scan_trigger)
      && scan_done) else $error("run without trigger");
   a_done_cause: assert property (scan_done |-> $past(scan_trigger))
      else $error("done without trigger");
   a_copy_atomic: assert property ((copy_sel != $past(copy_sel))
      |-> !$past(scan_trigger)) else $error("copy flip during scan");
endmodule

bind aus_scheduler aus_sched_asserts chk_u (.*);

// ---- verif/aus_host_model.sv ----
// Host model: AXI4-Lite master issuing scheduler commands
`timescale 1ns/1ps
module aus_host_model (
   // Clock
   input  wire logic        aclk,
   // Write channels
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // Idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h0;
      s_axi_wstrb = 4'hF;
   end
   // One write; released payload is inverted
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic aw_d;
      logic w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         if (!aw_d && s_axi_awready) begin
            aw_d = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (!w_d && s_axi_wready) begin
            w_d = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // One read
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ---- verif/tb_algorithm_update_scheduler.sv ----
// Testbench: scheduler queue, ratio, enable and swap behaviour
`timescale 1ns/1ps
module tb_algorithm_update_scheduler;
   import aus_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        scan_trigger = 1'b0, update_event = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, run_mask, copy_sel;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, scan_done;
   int          errors = 0, samples_checked = 0;
   logic [31:0] v;
   logic [1:0]  rr;
   // Clock, design and host
   always #25 aclk = ~aclk;
   aus_scheduler dut_u (.*);
   aus_host_model host_u (.*);
   task automatic chk(input logic [31:0] got, exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got,
                  exp);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      host_u.wr(a, d, rr);
      chk(rr, AXI_OKAY, "bresp");
   endtask
   task automatic r(input logic [7:0] a);
      host_u.rd(a, v, rr);
   endtask
   // Command with selector and data
   task automatic c(input logic [5:0] s, input logic [3:0] x,
                    input logic [3:0] cmd, input logic [31:0] d);
      w(SEL_OFF, {20'h0, x, 2'h0, s});
      w(WDATA_OFF, d);
      w(CMD_OFF, {28'h0, cmd});
   endtask
   task automatic q(input logic [5:0] s, input logic [3:0] x,
                    input logic [3:0] cmd);
      c(s, x, cmd, 32'h0);
      r(RDATA_OFF);
   endtask
   task automatic trig();
      @(posedge aclk);
      scan_trigger <= 1'b1;
      @(posedge aclk);
      scan_trigger <= 1'b0;
      #1 v = run_mask;
      chk(scan_done, 1'b1, "scan done");
   endtask
   task automatic evt();
      @(posedge aclk);
      update_event <= 1'b1;
      @(posedge aclk);
      update_event <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 2; i++) begin
         q(6'(i * 31), 4'h0, CMD_RATIO_RD);
         chk(v, 32'h1, "reset ratio");
         q(6'(i * 31), 4'h0, CMD_STATE_RD);
         chk(v, 32'h1, "reset state");
         q(6'(i * 31), 4'h0, CMD_SIZE_RD);
         chk(v, 32'h0, "reset size");
      end
   endtask
   task automatic t_scalar();
      w(DEFN_OFF, 32'h80000064);
      c(6'h0, 4'h0, CMD_DEFINE, 32'h0);
      q(6'h0, 4'h0, CMD_SIZE_RD);
      chk(v, 32'h000000C8, "swap size");
      c(6'h0, 4'h0, CMD_DEFVAR, 32'h0);
      c(6'h0, 4'h0, CMD_SCAL_WR, 32'h3F9E0419);
      r(STATUS_OFF);
      chk(v, 32'h1, "pending count");
      w(CTRL_OFF, 32'h1);
      r(STATUS_OFF);
      chk(v, 32'h0, "queue emptied");
      q(6'h0, 4'h0, CMD_SCAL_RD);
      chk(v, 32'h3F9E0419, "scalar value");
      w(DEFN_OFF, 32'h0);
      c(SHARED_SLOT, 4'h1, CMD_DEFINE, 32'h0);
      c(SHARED_SLOT, 4'h1, CMD_DEFVAR, 32'h0);
      c(SHARED_SLOT, 4'h1, CMD_SCAL_WR, 32'h3F8020C5);
      w(CTRL_OFF, 32'h1);
      q(SHARED_SLOT, 4'h1, CMD_SCAL_RD);
      chk(v, 32'h3F8020C5, "shared value");
      q(6'h0, 4'h3, CMD_SCAL_RD);
      r(ERR_OFF);
      chk(v[ERR_UNDEF], 1'b1, "undefined var");
      w(ERR_OFF, 32'hF);
   endtask
   task automatic t_window();
      w(WINDOW_OFF, 32'h2);
      for (int i = 0; i < 3; i++) c(6'h2, 4'h0, CMD_RATIO_WR, 32'h4);
      r(STATUS_OFF);
      chk(v, 32'h2, "window count");
      r(ERR_OFF);
      chk(v[ERR_TOOMANY], 1'b1, "too many");
      w(CTRL_OFF, 32'h1);
      w(WINDOW_OFF, 32'h10);
      w(ERR_OFF, 32'hF);
      c(6'h2, 4'h0, CMD_RATIO_WR, 32'h8000);
      r(ERR_OFF);
      chk(v[ERR_BADARG], 1'b1, "ratio over range");
      w(ERR_OFF, 32'hF);
   endtask
   task automatic t_ratio();
      c(6'h0, 4'h0, CMD_RATIO_WR, 32'h3);
      c(6'h1, 4'h0, CMD_RATIO_WR, 32'h7FFF);
      q(6'h0, 4'h0, CMD_RATIO_RD);
      chk(v, 32'h1, "ratio pending");
      w(CTRL_OFF, 32'h1);
      q(6'h0, 4'h0, CMD_RATIO_RD);
      chk(v, 32'h3, "ratio applied");
      q(6'h1, 4'h0, CMD_RATIO_RD);
      chk(v, 32'h7FFF, "undefined ratio");
      w(CTRL_OFF, 32'h2);
      for (int i = 0; i < 7; i++) begin
         trig();
         chk(v, {31'h0, i % 3 == 0}, "ratio pacing");
      end
   endtask
   task automatic t_state();
      c(6'h0, 4'h0, CMD_STATE_WR, 32'h0);
      for (int i = 7; i < 10; i++) begin
         trig();
         chk(v, {31'h0, i % 3 == 0}, "disable pending");
      end
      w(CHAN_OFF, 32'h1);
      evt();
      for (int i = 0; i < 3; i++) begin
         trig();
         chk(v, 32'h0, "disabled slot");
      end
      q(6'h0, 4'h0, CMD_STATE_RD);
      chk(v, 32'h0, "state query");
   endtask
   task automatic t_swap();
      c(6'h0, 4'h0, CMD_REPLACE, 32'h0);
      chk(copy_sel, 32'h0, "copy pending");
      w(CTRL_OFF, 32'h1);
      repeat (2) @(posedge aclk);
      chk(copy_sel, 32'h1, "copy flipped");
      c(6'h0, 4'h0, CMD_REPLACE, 32'h0);
      evt();
      chk(copy_sel, 32'h0, "copy back");
      host_u.rd(8'h3C, v, rr);
      chk(rr, AXI_SLVERR, "unmapped read");
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #2000000;
      errors++;
      final_report();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_scalar();
      t_window();
      t_ratio();
      t_state();
      t_swap();
      final_report();
   end
endmodule
